// file: hdl/dtr_pkg.sv
// Types shared by the DMA request controller.
package dtr_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_XFER = 2'h2
    } dtr_state_t;

    typedef enum logic [3:0] {
        OWN_CPU     = 4'h1,
        OWN_DMA     = 4'h2,
        OWN_HOLD    = 4'h4,
        OWN_REFRESH = 4'h8
    } dtr_owner_t;

    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] ctrl;
        logic [15:0] cnt;
        logic [15:0] cnt_init;
        logic [15:0] blk;
    } dtr_chan_t;
endpackage : dtr_pkg

// file: hdl/dtr_regs.svh
// Register offsets, field positions, reset values and cycle counts of the DMA request controller.
// Summary of operation
// [RULE1] Mode register bit 2 picks burst (0) or cycle-steal (1); reset gives burst.
// [RULE2] In burst mode an accepted channel locks out all others until it ends or stops.
// [RULE3] Control register bit 4 picks edge (0) or level (1) sensing; reset gives edge.
// [RULE4] Software uses level sensing only for the pin source in burst mode.
// [RULE5] Edge sensing sets the request flag on a falling request pin.
// [RULE6] Burst edge flag clears on permission clear, software clear, end, or stop pin low.
// [RULE7] Bus priority is refresh, then hold, then DMA, then CPU.
// [RULE8] Refresh stops DMA at the cycle end; transfer resumes where it stopped.
// [RULE9] After a burst ends the CPU gets one bus cycle before another channel starts.
// [RULE10] Level sensing makes the flag follow the pin: 1 while low, 0 while high.
// [RULE11] Level pin high mid-transfer pauses at cycle end, keeps permission, resumes later.
// [RULE12] A finished level-sensed burst clears permission and returns the bus to the CPU.
// [RULE13] Software uses edge sensing on every cycle-steal channel.
// [RULE14] Cycle-steal clears the request flag when the serving transfer cycle starts.
// [RULE15] Cycle-steal moves one unit per grant, keeping the bus only if requests remain.
// [RULE16] Cycle-steal re-ranks channels at every cycle end and starts the highest one.
// [RULE17] Cycle-steal flag clearing keeps permission; a new flag resumes the channel.
// [RULE18] Counter at 0, or counter and block counter at 0 in chain mode, ends transfer.
// [RULE19] A new falling pin edge during a cycle-steal cycle sets the flag again.
// [RULE20] A channel is accepted only with permission and flag both 1; reset clears permission.
// [RULE21] Fixed priority ranks channels 0, 1, 2, 3 from highest to lowest.
// [RULE22] Request and stop pins pass a two-stage synchroniser before any use.
`ifndef DTR_REGS_SVH
`define DTR_REGS_SVH
`define DTR_GCTL_OFS        8'h00
`define DTR_FLAG_OFS        8'h04
`define DTR_STAT_OFS        8'h08
`define DTR_MODE_SUB        4'h0
`define DTR_CTRL_SUB        4'h4
`define DTR_CNT_SUB         4'h8
`define DTR_BLK_SUB         4'hc
`define DTR_MODE_CHAIN_BIT  0
`define DTR_MODE_CSTEAL_BIT 2
`define DTR_CTRL_LEVEL_BIT  4
`define DTR_SRC_EXT         4'h1
`define DTR_SRC_SW          4'h2
`define DTR_SWREQ_LSB       8
`define DTR_REG_RESET       16'h0000
`define DTR_XFER_CYCLES     2
`define DTR_CPU_GAP_CYCLES  2
`define DTR_RESP_OKAY       2'h0
`define DTR_RESP_SLVERR     2'h2
`endif

// file: hdl/dtr_top.sv
// DMA request, transfer-mode and bus-ownership control for four channels.
`timescale 1ns/1ps
`include "dtr_regs.svh"
module dtr_top #(
    parameter int XFER_CYCLES    = `DTR_XFER_CYCLES,
    parameter int CPU_GAP_CYCLES = `DTR_CPU_GAP_CYCLES
) (
    input  wire logic        I_REF_CLK,
    input  wire logic        I_SYS_RST,
    input  wire logic [7:0]  I_S_AXI_AWADDR,
    input  wire logic        I_S_AXI_AWVALID,
    output wire logic        O_S_AXI_AWREADY,
    input  wire logic [31:0] I_S_AXI_WDATA,
    input  wire logic [3:0]  I_S_AXI_WSTRB,
    input  wire logic        I_S_AXI_WVALID,
    output wire logic        O_S_AXI_WREADY,
    output wire logic [1:0]  O_S_AXI_BRESP,
    output wire logic        O_S_AXI_BVALID,
    input  wire logic        I_S_AXI_BREADY,
    input  wire logic [7:0]  I_S_AXI_ARADDR,
    input  wire logic        I_S_AXI_ARVALID,
    output wire logic        O_S_AXI_ARREADY,
    output wire logic [31:0] O_S_AXI_RDATA,
    output wire logic [1:0]  O_S_AXI_RRESP,
    output wire logic        O_S_AXI_RVALID,
    input  wire logic        I_S_AXI_RREADY,
    input  wire logic [3:0]  I_EXTERNAL_REQUEST_PIN_N,
    input  wire logic        I_FORCED_STOP_PIN_N,
    input  wire logic        I_REFRESH_REQ,
    input  wire logic        I_HOLD_REQ,
    output wire logic [3:0]  O_BUS_OWNER,
    output wire logic        O_XFER_START,
    output wire logic [1:0]  O_XFER_CHAN
);
    localparam logic [3:0] CYC_LAST = 4'(XFER_CYCLES - 1);
    localparam logic [3:0] GAP_INIT = 4'(CPU_GAP_CYCLES);

    generate
        if (XFER_CYCLES < 1 || XFER_CYCLES > 16 || CPU_GAP_CYCLES < 2 || CPU_GAP_CYCLES > 15)
        begin : g_bad_param
            $error("dtr_top: cycle count parameter out of range");
        end
    endgenerate

    logic [3:0]             req_s1_r;
    logic [3:0]             req_s2_r;
    logic [3:0]             req_s3_r;
    logic                   stop_s1_r;
    logic                   stop_s2_r;
    dtr_pkg::dtr_chan_t     chan_r [4];
    logic [3:0]             perm_r;
    logic [3:0]             flag_r;
    dtr_pkg::dtr_state_t    state_r;
    dtr_pkg::dtr_state_t    state_nxt;
    dtr_pkg::dtr_owner_t    owner_r;
    dtr_pkg::dtr_owner_t    owner_nxt;
    logic [1:0]             chan_cur_r;
    logic [1:0]             lock_ch_r;
    logic                   lock_v_r;
    logic                   stop_pend_r;
    logic [3:0]             cyc_cnt_r;
    logic [3:0]             gap_r;
    logic                   start_r;
    logic [1:0]             pick;
    logic                   aw_hold_r;
    logic                   w_hold_r;
    logic [7:0]             awaddr_r;
    logic [31:0]            wdata_r;
    logic [3:0]             wstrb_r;
    logic                   bvalid_r;
    logic [1:0]             bresp_r;
    logic                   rvalid_r;
    logic [31:0]            rdata_r;
    logic [1:0]             rresp_r;
    logic [31:0]            rd_data;
    logic                   rd_ok;

    // Pins come from outside the clock domain; logic reads the second stage, and the third only for request edge detection.
    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SYS_RST)
        begin
            req_s1_r  <= 4'hf;
            req_s2_r  <= 4'hf;
            req_s3_r  <= 4'hf;
            stop_s1_r <= 1'b1;
            stop_s2_r <= 1'b1;
        end
        else
        begin
            req_s1_r  <= I_EXTERNAL_REQUEST_PIN_N; // see [RULE22]
            req_s2_r  <= req_s1_r;
            req_s3_r  <= req_s2_r;
            stop_s1_r <= I_FORCED_STOP_PIN_N; // see [RULE22]
            stop_s2_r <= stop_s1_r;
        end
    end

    wire [3:0]  req_fall = req_s3_r & ~req_s2_r;

    // Register write decode.
    wire        wr_fire  = aw_hold_r & w_hold_r & ~bvalid_r;
    wire        wr_ch_ok = (awaddr_r[7:4] >= 4'h1) && (awaddr_r[7:4] <= 4'h4);
    wire        wr_al    = awaddr_r[1:0] == 2'h0;
    wire        gctl_wr  = wr_fire && awaddr_r == `DTR_GCTL_OFS;
    wire        flag_wr  = wr_fire && awaddr_r == `DTR_FLAG_OFS;
    wire        stat_hit = awaddr_r == `DTR_STAT_OFS;
    wire        ch_wr    = wr_fire & wr_ch_ok & wr_al;
    wire [1:0]  wr_ch    = awaddr_r[5:4] - 2'h1;
    wire [15:0] wmask    = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    wire [15:0] wr_bits  = wdata_r[15:0] & wmask;
    wire        wr_good  = ch_wr | gctl_wr | flag_wr | (stat_hit & wr_fire);

    // Transfer engine decode.
    wire        in_xfer   = state_r == dtr_pkg::ST_XFER;
    wire        bus_busy  = I_REFRESH_REQ | I_HOLD_REQ;
    wire        cyc_end   = in_xfer && cyc_cnt_r == 4'h0;
    dtr_pkg::dtr_chan_t cur;
    assign cur = chan_r[chan_cur_r];
    wire [15:0] cnt_dec   = cur.cnt - 16'h1;
    wire        cur_chain = cur.mode[`DTR_MODE_CHAIN_BIT];
    wire        cur_burst = ~cur.mode[`DTR_MODE_CSTEAL_BIT];
    wire        all_done  = cnt_dec == 16'h0 && (!cur_chain || cur.blk == 16'h0);
    wire        whole_end = cyc_end & all_done; // see [RULE18]
    wire        stop_now  = in_xfer & ~stop_s2_r;
    wire        term      = cyc_end & (all_done | stop_pend_r | stop_now);
    wire [3:0]  eligible;
    wire [3:0]  cs_clr;
    wire [3:0]  level_m;
    wire [3:0]  ext_m;
    wire        any_elig  = |eligible;
    wire        idle_ok   = state_r == dtr_pkg::ST_IDLE && gap_r == 4'h0; // see [RULE9]
    // A cycle never breaks mid-way; refresh or hold wait for its end.
    wire        go        = any_elig & ~bus_busy & (idle_ok | (cyc_end & ~term)); // see [RULE8]

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_ch
            wire is_lock = lock_ch_r == 2'(gi);
            assign ext_m[gi]    = chan_r[gi].ctrl[3:0] == `DTR_SRC_EXT;
            assign level_m[gi]  = ext_m[gi] & chan_r[gi].ctrl[`DTR_CTRL_LEVEL_BIT]; // see [RULE3]
            assign eligible[gi] = perm_r[gi] & flag_r[gi] & (~lock_v_r | is_lock); // see [RULE20]
            assign cs_clr[gi]   = go && pick == 2'(gi)
                                  && chan_r[gi].mode[`DTR_MODE_CSTEAL_BIT]; // see [RULE14]
        end
    endgenerate

    // Lowest numbered eligible channel wins.
    always_comb
    begin
        pick = 2'h0;
        for (int k = 3; k >= 0; k--)
        begin
            if (eligible[k])
            begin
                pick = 2'(k); // see [RULE21]
            end
        end
    end

    assign state_nxt = go ? dtr_pkg::ST_XFER : (cyc_end ? dtr_pkg::ST_IDLE : state_r);
    assign owner_nxt = (state_nxt == dtr_pkg::ST_XFER) ? dtr_pkg::OWN_DMA :
                       I_REFRESH_REQ ? dtr_pkg::OWN_REFRESH :
                       I_HOLD_REQ ? dtr_pkg::OWN_HOLD : dtr_pkg::OWN_CPU; // see [RULE7]

    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SYS_RST)
        begin
            state_r     <= dtr_pkg::ST_IDLE;
            owner_r     <= dtr_pkg::OWN_CPU;
            chan_cur_r  <= 2'h0;
            cyc_cnt_r   <= 4'h0;
            start_r     <= 1'b0;
            stop_pend_r <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            owner_r     <= owner_nxt; // see [RULE15]
            start_r     <= go;
            stop_pend_r <= cyc_end ? 1'b0 : (stop_pend_r | stop_now);
            if (go)
            begin
                chan_cur_r <= pick; // see [RULE16]
                cyc_cnt_r  <= CYC_LAST;
            end
            else if (in_xfer)
            begin
                cyc_cnt_r <= cyc_cnt_r - 4'h1;
            end
        end
    end

    // Burst lock and the CPU bus cycle that follows a finished burst.
    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SYS_RST)
        begin
            lock_v_r  <= 1'b0;
            lock_ch_r <= 2'h0;
            gap_r     <= 4'h0;
        end
        else
        begin
            if (term)
            begin
                lock_v_r <= 1'b0;
            end
            else if (go && !chan_r[pick].mode[`DTR_MODE_CSTEAL_BIT])
            begin
                lock_v_r  <= 1'b1; // see [RULE2]
                lock_ch_r <= pick;
            end
            else if (lock_v_r && !perm_r[lock_ch_r])
            begin
                lock_v_r <= 1'b0;
            end
            if (term && cur_burst)
            begin
                gap_r <= GAP_INIT; // see [RULE9]
            end
            else if (gap_r != 4'h0)
            begin
                gap_r <= gap_r - 4'h1;
            end
        end
    end

    // Channel registers, permission bits and request flags.
    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SYS_RST)
        begin
            perm_r <= 4'h0; // see [RULE20]
            flag_r <= 4'h0;
            for (int k = 0; k < 4; k++)
            begin
                chan_r[k] <= '0; // see [RULE1]
            end
        end
        else
        begin
            for (int k = 0; k < 4; k++)
            begin
                automatic logic is_cur = chan_cur_r == 2'(k);
                automatic logic sw_set = flag_wr && wstrb_r[1] && wdata_r[`DTR_SWREQ_LSB + k]
                                         && chan_r[k].ctrl[3:0] == `DTR_SRC_SW;
                automatic logic set_f  = (ext_m[k] & req_fall[k]) | sw_set; // see [RULE5]
                automatic logic clr_f  = (gctl_wr & wstrb_r[0] & ~wdata_r[k])
                                         | (flag_wr & wstrb_r[0] & ~wdata_r[k])
                                         | (whole_end & is_cur) | (stop_now & is_cur)
                                         | cs_clr[k]; // see [RULE6]
                if (level_m[k])
                begin
                    flag_r[k] <= ~req_s2_r[k]; // see [RULE10] [RULE11]
                end
                else if (set_f)
                begin
                    flag_r[k] <= 1'b1; // see [RULE19] [RULE17]
                end
                else if (clr_f)
                begin
                    flag_r[k] <= 1'b0;
                end
                if (gctl_wr && wstrb_r[0])
                begin
                    perm_r[k] <= wdata_r[k];
                end
                else if (whole_end && is_cur)
                begin
                    perm_r[k] <= 1'b0; // see [RULE12] [RULE18]
                end
                if (ch_wr && wr_ch == 2'(k))
                begin
                    case (awaddr_r[3:0])
                        `DTR_MODE_SUB:
                            chan_r[k].mode <= (chan_r[k].mode & ~wmask) | (wdata_r[15:0] & wmask);
                        `DTR_CTRL_SUB:
                            chan_r[k].ctrl <= (chan_r[k].ctrl & ~wmask) | (wdata_r[15:0] & wmask);
                        `DTR_CNT_SUB:
                        begin
                            chan_r[k].cnt      <= (chan_r[k].cnt & ~wmask) | wr_bits;
                            chan_r[k].cnt_init <= (chan_r[k].cnt_init & ~wmask) | wr_bits;
                        end
                        default:
                            chan_r[k].blk <= (chan_r[k].blk & ~wmask) | (wdata_r[15:0] & wmask);
                    endcase
                end
                else if (cyc_end && is_cur)
                begin
                    if (cnt_dec == 16'h0 && cur_chain && chan_r[k].blk != 16'h0)
                    begin
                        chan_r[k].cnt <= chan_r[k].cnt_init;
                        chan_r[k].blk <= chan_r[k].blk - 16'h1;
                    end
                    else
                    begin
                        chan_r[k].cnt <= cnt_dec;
                    end
                end
            end
        end
    end

    // Register read mux.
    wire [1:0]  rd_ch    = I_S_AXI_ARADDR[5:4] - 2'h1;
    wire        rd_ch_ok = I_S_AXI_ARADDR[7:4] >= 4'h1 && I_S_AXI_ARADDR[7:4] <= 4'h4;
    always_comb
    begin
        rd_data = 32'h0;
        rd_ok   = I_S_AXI_ARADDR[1:0] == 2'h0;
        if (rd_ch_ok)
        begin
            case (I_S_AXI_ARADDR[3:0])
                `DTR_MODE_SUB: rd_data = {16'h0, chan_r[rd_ch].mode};
                `DTR_CTRL_SUB: rd_data = {16'h0, chan_r[rd_ch].ctrl};
                `DTR_CNT_SUB:  rd_data = {16'h0, chan_r[rd_ch].cnt};
                default:       rd_data = {16'h0, chan_r[rd_ch].blk};
            endcase
        end
        else if (I_S_AXI_ARADDR == `DTR_GCTL_OFS)
        begin
            rd_data = {28'h0, perm_r};
        end
        else if (I_S_AXI_ARADDR == `DTR_FLAG_OFS)
        begin
            rd_data = {28'h0, flag_r};
        end
        else if (I_S_AXI_ARADDR == `DTR_STAT_OFS)
        begin
            rd_data = {22'h0, owner_r, lock_v_r, lock_ch_r, chan_cur_r, in_xfer};
        end
        else
        begin
            rd_ok = 1'b0;
        end
    end

    // AXI4-Lite slave: address and data latch in either order, response after both.
    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SYS_RST)
        begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= 8'h0;
            wdata_r   <= 32'h0;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `DTR_RESP_OKAY;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0;
            rresp_r   <= `DTR_RESP_OKAY;
        end
        else
        begin
            if (I_S_AXI_AWVALID && O_S_AXI_AWREADY)
            begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= I_S_AXI_AWADDR;
            end
            if (I_S_AXI_WVALID && O_S_AXI_WREADY)
            begin
                w_hold_r <= 1'b1;
                wdata_r  <= I_S_AXI_WDATA;
                wstrb_r  <= I_S_AXI_WSTRB;
            end
            if (wr_fire)
            begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_good ? `DTR_RESP_OKAY : `DTR_RESP_SLVERR;
            end
            else if (I_S_AXI_BREADY)
            begin
                bvalid_r <= 1'b0;
            end
            if (I_S_AXI_ARVALID && O_S_AXI_ARREADY)
            begin
                rvalid_r <= 1'b1;
                rdata_r  <= rd_ok ? rd_data : 32'h0;
                rresp_r  <= rd_ok ? `DTR_RESP_OKAY : `DTR_RESP_SLVERR;
            end
            else if (I_S_AXI_RREADY)
            begin
                rvalid_r <= 1'b0;
            end
        end
    end

    assign O_S_AXI_AWREADY = ~aw_hold_r & ~bvalid_r;
    assign O_S_AXI_WREADY  = ~w_hold_r & ~bvalid_r;
    assign O_S_AXI_BVALID  = bvalid_r;
    assign O_S_AXI_BRESP   = bresp_r;
    assign O_S_AXI_ARREADY = ~rvalid_r;
    assign O_S_AXI_RVALID  = rvalid_r;
    assign O_S_AXI_RDATA   = rdata_r;
    assign O_S_AXI_RRESP   = rresp_r;
    assign O_BUS_OWNER     = owner_r;
    assign O_XFER_START    = start_r;
    assign O_XFER_CHAN     = chan_cur_r;

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_SYS_RST);

    sequence s_burst_done;
        term && cur_burst;
    endsequence
    sequence s_refresh_at_end;
        cyc_end && I_REFRESH_REQ;
    endsequence

    property p_reset_burst;
        $past(I_SYS_RST) |-> !chan_r[0].mode[`DTR_MODE_CSTEAL_BIT];
    endproperty
    a_reset_burst: assert property (p_reset_burst) else $error("mode not burst"); // see [RULE1]
    property p_lock_only;
        lock_v_r && go |-> pick == lock_ch_r;
    endproperty
    a_lock_only: assert property (p_lock_only) else $error("lock broken"); // see [RULE2]
    property p_level_follow;
        level_m != 4'h0 |=> ((flag_r ^ ~$past(req_s2_r)) & $past(level_m)) == 4'h0;
    endproperty
    a_level_follow: assert property (p_level_follow) else $error("flag not pin"); // see [RULE10]
    property p_edge_set;
        ext_m[0] && !level_m[0] && req_fall[0] |=> flag_r[0];
    endproperty
    a_edge_set: assert property (p_edge_set) else $error("edge set no flag"); // see [RULE5]
    property p_refresh_first;
        !in_xfer && I_REFRESH_REQ |=> owner_r == dtr_pkg::OWN_REFRESH;
    endproperty
    a_refresh_first: assert property (p_refresh_first) else $error("no refresh"); // see [RULE7]
    property p_refresh_yield;
        s_refresh_at_end |=> state_r == dtr_pkg::ST_IDLE ##0 owner_r == dtr_pkg::OWN_REFRESH;
    endproperty
    a_refresh_yield: assert property (p_refresh_yield) else $error("bus kept"); // see [RULE8]
    property p_cpu_gap;
        s_burst_done |=> (!go && owner_r != dtr_pkg::OWN_DMA)[*2];
    endproperty
    a_cpu_gap: assert property (p_cpu_gap) else $error("no CPU cycle after burst"); // see [RULE9]
    property p_cs_clear;
        (cs_clr & ~req_fall & ~level_m) != 4'h0 && !flag_wr
            |=> (flag_r & $past(cs_clr & ~req_fall & ~level_m)) == 4'h0;
    endproperty
    a_cs_clear: assert property (p_cs_clear) else $error("steal start kept flag"); // see [RULE14]
    property p_cs_release;
        cyc_end && !any_elig |=> owner_r != dtr_pkg::OWN_DMA;
    endproperty
    a_cs_release: assert property (p_cs_release) else $error("bus kept idle"); // see [RULE15]
    property p_accept;
        go |-> perm_r[pick] && flag_r[pick] ##1 O_XFER_START && O_XFER_CHAN == $past(pick);
    endproperty
    a_accept: assert property (p_accept) else $error("start without grant"); // see [RULE20]
    property p_end_perm;
        whole_end && !gctl_wr |=> !perm_r[$past(chan_cur_r)];
    endproperty
    a_end_perm: assert property (p_end_perm) else $error("permission kept"); // see [RULE18]
    property p_fixed_rank;
        go && eligible[0] |-> pick == 2'h0;
    endproperty
    a_fixed_rank: assert property (p_fixed_rank) else $error("rank broken"); // see [RULE21]
endmodule : dtr_top

// file: sim/dma_transfer_mode_request_control_test.sv
// Self-checking bench for the DMA request and transfer-mode controller.
`timescale 1ns/1ps
module dma_transfer_mode_request_control_test;
    logic clk = 0, rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, refr = 0, hold = 0;
    logic stop = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata_w, rd;
    logic [1:0] bresp, rresp, chan;
    logic [3:0] want = 0, owner, req_n;
    logic awready, wready, bvalid, arready, rvalid, start, stop_n;
    int miscompares = 0, n_checks = 0, gap;
    dtr_top u_dtr_top (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_S_AXI_AWADDR(awaddr),
        .I_S_AXI_AWVALID(awv), .O_S_AXI_AWREADY(awready), .I_S_AXI_WDATA(wdata),
        .I_S_AXI_WSTRB(4'hf), .I_S_AXI_WVALID(wv), .O_S_AXI_WREADY(wready),
        .O_S_AXI_BRESP(bresp), .O_S_AXI_BVALID(bvalid), .I_S_AXI_BREADY(bready),
        .I_S_AXI_ARADDR(araddr), .I_S_AXI_ARVALID(arv), .O_S_AXI_ARREADY(arready),
        .O_S_AXI_RDATA(rdata_w), .O_S_AXI_RRESP(rresp), .O_S_AXI_RVALID(rvalid),
        .I_S_AXI_RREADY(rready), .I_EXTERNAL_REQUEST_PIN_N(req_n),
        .I_FORCED_STOP_PIN_N(stop_n), .I_REFRESH_REQ(refr), .I_HOLD_REQ(hold),
        .O_BUS_OWNER(owner), .O_XFER_START(start), .O_XFER_CHAN(chan));
    dtr_req_dev u_dtr_req_dev (.i_clk(clk), .i_want(want), .i_stop(stop), .o_req_n(req_n),
        .o_stop_n(stop_n));
    initial
    begin
        forever #4 clk = ~clk;
    end
    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task tmo(input int n);
        if (n >= 200)
        begin
            miscompares++;
            $display("ERROR wait expected done seen timeout");
            end_of_test();
        end
    endtask : tmo
    task axw(input logic [7:0] a, input logic [15:0] d);
        int n;
        awaddr <= a; wdata <= {16'h0000, d}; awv <= 1; wv <= 1; bready <= 1; n = 0;
        do
        begin
            @(posedge clk);
            if (awready) awv <= 0;
            if (wready) wv <= 0;
            n++;
        end
        while (bvalid !== 1'b1 && n < 200);
        bready <= 0;
        tmo(n);
        chk("bresp", 32'h0, {30'h0, bresp});
        @(posedge clk);
    endtask : axw
    task axr(input logic [7:0] a);
        int n;
        araddr <= a; arv <= 1; rready <= 1; n = 0;
        do
        begin
            @(posedge clk);
            if (arready) arv <= 0;
            n++;
        end
        while (rvalid !== 1'b1 && n < 200);
        rd = rdata_w;
        rready <= 0;
        tmo(n);
        @(posedge clk);
    endtask : axr
    task wst;
        gap = 0;
        do
        begin
            @(posedge clk);
            gap++;
        end
        while (start !== 1'b1 && gap < 200);
        tmo(gap);
    endtask : wst
    task t_reset;
        axr(8'h00); chk("perm", 32'h0, rd);
        axr(8'h10); chk("mode0", 32'h0, rd);
        axr(8'h14); chk("ctrl0", 32'h0, rd);
        axr(8'hfc); chk("rresp", 32'h2, {30'h0, rresp});
        $display("test reset done");
    endtask : t_reset
    task t_burst;
        axw(8'h14, 16'h0001); axw(8'h24, 16'h0001);
        axw(8'h18, 16'h0001); axw(8'h28, 16'h0004);
        axw(8'h00, 16'h0003);
        want <= 4'h2;
        wst(); chk("chan", 32'h1, {30'h0, chan});
        chk("owner", 32'h2, {28'h0, owner});
        want <= 4'h3;
        repeat (3)
        begin
            wst(); chk("locked", 32'h1, {30'h0, chan});
        end
        wst(); chk("next", 32'h0, {30'h0, chan});
        chk("cpugap", 32'h1, {31'h0, gap > 3});
        repeat (8) @(posedge clk);
        axr(8'h00); chk("permend", 32'h0, rd);
        axr(8'h04); chk("flagend", 32'h0, rd);
        want <= 4'h0;
        $display("test burst done");
    endtask : t_burst
    task t_steal;
        axw(8'h30, 16'h0004); axw(8'h34, 16'h0001);
        axw(8'h38, 16'h0003); axw(8'h00, 16'h0004);
        want <= 4'h4;
        wst(); chk("schan", 32'h2, {30'h0, chan});
        axr(8'h04); chk("sflag", 32'h0, rd);
        axr(8'h00); chk("sperm", 32'h4, rd);
        want <= 4'h0;
        repeat (4) @(posedge clk);
        want <= 4'h4;
        wst(); chk("resume", 32'h2, {30'h0, chan});
        repeat (6) @(posedge clk);
        axr(8'h38); chk("scnt", 32'h1, rd);
        want <= 4'h0;
        $display("test steal done");
    endtask : t_steal
    task t_level;
        axw(8'h44, 16'h0011);
        want <= 4'h8;
        repeat (6) @(posedge clk);
        axr(8'h04); chk("lvlon", 32'h8, rd);
        want <= 4'h0;
        repeat (6) @(posedge clk);
        axr(8'h04); chk("lvloff", 32'h0, rd);
        $display("test level done");
    endtask : t_level
    task t_stop;
        axw(8'h18, 16'h0008);
        axw(8'h00, 16'h0001);
        want <= 4'h1;
        wst();
        refr <= 1;
        repeat (4) @(posedge clk);
        chk("rfown", 32'h8, {28'h0, owner});
        refr <= 0;
        wst(); chk("rfres", 32'h0, {30'h0, chan});
        stop <= 1;
        repeat (8) @(posedge clk);
        axr(8'h04); chk("stflag", 32'h0, rd);
        axr(8'h00); chk("stperm", 32'h1, rd);
        stop <= 0;
        want <= 4'h0;
        $display("test stop done");
    endtask : t_stop
    task t_owner;
        refr <= 1; hold <= 1;
        repeat (4) @(posedge clk);
        chk("refresh", 32'h8, {28'h0, owner});
        refr <= 0;
        repeat (4) @(posedge clk);
        chk("hold", 32'h4, {28'h0, owner});
        hold <= 0;
        repeat (4) @(posedge clk);
        chk("cpu", 32'h1, {28'h0, owner});
        $display("test owner done");
    endtask : t_owner
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 0;
        t_reset();
        t_burst();
        t_steal();
        t_level();
        t_stop();
        t_owner();
        end_of_test();
    end
endmodule : dma_transfer_mode_request_control_test

// file: sim/dtr_req_dev.sv
// Model of the requesting I/O device that drives the request and forced-stop pins.
`timescale 1ns/1ps
module dtr_req_dev (
    input  wire logic       i_clk,
    input  wire logic [3:0] i_want,
    input  wire logic       i_stop,
    output logic      [3:0] o_req_n,
    output logic            o_stop_n
);
    // A pin falls when the device wants service and stays low while it wants it.
    always_ff @(posedge i_clk)
    begin
        o_req_n  <= ~i_want;
        o_stop_n <= ~i_stop;
    end
endmodule : dtr_req_dev
